// *** hdl/smch_master.sv ***
`timescale 1ns/1ps
// Summary of operation
// - hold feature only in master mode, driven by word bit 28.
// - word with hold at one keeps select asserted after its transfer.
// - word with hold at zero releases select after its transfer.
// - one write carries 16-bit data low, control high, and starts sending.
// - no select glitch when a word follows a held word.
module smch_master
   import smch_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic master_mode,
   input wire logic [WORD_W-1:0] tx_control_data_word,
   input wire logic tx_write,
   output logic tx_ready,
   output logic serial_clock_out,
   output logic master_serial_out,
   output logic chip_select_out_n,
   output logic busy
);
   smch_if #(.W(WORD_W)) wr_s ();
   smch_if #(.W(WORD_W)) rd_s ();

   typedef struct packed {
      smch_state_t state;
      logic [DATA_W-1:0] shreg;
      logic [4:0] bitcnt;
      logic [7:0] halfcnt;
      logic phase;
      logic hold;
      logic sclk;
      logic mosi;
      logic cs_n;
   } smch_st_t;
   smch_st_t st_reg, st_next;

   // write port feeds the fifo; ready stalls the writer when full
   assign wr_s.valid = tx_write;
   assign wr_s.data = tx_control_data_word;
   assign tx_ready = wr_s.ready;

   smch_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .rst(rst),
      .in_s(wr_s),
      .out_s(rd_s)
   );

   // idle and hold both accept the next word; the checks below reuse this decode
   function automatic logic can_take(input smch_state_t s);
      return (s == SMCH_IDLE) || (s == SMCH_HOLD);
   endfunction

   // the engine only pulls a word while master mode is on, so words wait in the fifo
   logic take;
   assign take = rd_s.valid && master_mode && can_take(st_reg.state);
   assign rd_s.ready = take;

   // timing of one word, in core cycles after the engine takes it:
   // select falls and the msb is driven together with the load, clock still low;
   // each clock half lasts HALF_RELOAD + 1 cycles, counted down in halfcnt;
   // data moves on the falling edge so the slave sees it settled a half period;
   // after the sixteenth high half the clock falls and select rises in that same
   // cycle unless hold was set, in which case select is left low with no clock.
   // shift engine: mode 0, msb first, data changes on falling edge
   always_comb begin
      st_next = st_reg;
      case (st_reg.state)
         SMCH_IDLE, SMCH_HOLD: begin
            if (take) begin
               st_next.shreg = rd_s.data[DATA_W-1:0];
               st_next.mosi = rd_s.data[DATA_W-1];
               st_next.hold = rd_s.data[HOLD_BIT];
               st_next.bitcnt = '0;
               st_next.halfcnt = HALF_RELOAD;
               st_next.phase = 1'b0;
               st_next.sclk = 1'b0;
               st_next.cs_n = 1'b0;
               st_next.state = SMCH_SHIFT;
            // idle with nothing queued keeps select high; hold leaves it alone
            end else if (st_reg.state == SMCH_IDLE) begin
               st_next.cs_n = 1'b1;
            end
         end
         SMCH_SHIFT: begin
            // count down one clock half, then toggle the clock
            if (st_reg.halfcnt != 8'h00) begin
               st_next.halfcnt = st_reg.halfcnt - 8'h01;
            end else begin
               st_next.halfcnt = HALF_RELOAD;
               st_next.phase = !st_reg.phase;
               st_next.sclk = !st_reg.phase;
               if (st_reg.phase) begin
                  if (st_reg.bitcnt == BIT_LAST) begin
                     if (st_reg.hold) begin
                        st_next.state = SMCH_HOLD;
                     end else begin
                        st_next.cs_n = 1'b1;
                        st_next.state = SMCH_IDLE;
                     end
                  end else begin
                     st_next.bitcnt = st_reg.bitcnt + 5'h01;
                     st_next.shreg = {st_reg.shreg[DATA_W-2:0], 1'b0};
                     st_next.mosi = st_reg.shreg[DATA_W-2];
                  end
               end
            end
         end
         default: begin
            st_next.state = SMCH_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_reg <= '{state: SMCH_IDLE, cs_n: 1'b1, default: '0};
      end else begin
         st_reg <= st_next;
      end
   end

   // select, clock and data come straight from flops (busy is a state decode) so select and clock cannot glitch
   // on decode hazards, which a held select relies on
   assign serial_clock_out = st_reg.sclk;
   assign master_serial_out = st_reg.mosi;
   assign chip_select_out_n = st_reg.cs_n;
   assign busy = st_reg.state == SMCH_SHIFT;

   a_cs_no_glitch: assert property (@(posedge clk) disable iff (rst)
      (st_reg.state == SMCH_HOLD && take) |=> !chip_select_out_n)
      else $error("select rose when a word followed a held word");
   a_hold_stays: assert property (@(posedge clk) disable iff (rst)
      (st_reg.state == SMCH_HOLD) |-> !chip_select_out_n)
      else $error("select released while holding");
   // hold word ends in hold state
   a_hold_kept: assert property (@(posedge clk) disable iff (rst)
      (busy && st_reg.hold && st_next.state != SMCH_SHIFT) |=>
      (st_reg.state == SMCH_HOLD && !chip_select_out_n))
      else $error("hold word did not keep select");
   a_release: assert property (@(posedge clk) disable iff (rst)
      (busy && !st_reg.hold && st_next.state != SMCH_SHIFT) |=> chip_select_out_n)
      else $error("select not released after final word");
   a_master_only: assert property (@(posedge clk) disable iff (rst)
      (!master_mode && !busy) |=> !busy)
      else $error("transfer started outside master mode");
   // take starts shift with select low
   a_start: assert property (@(posedge clk) disable iff (rst)
      take |=> (busy && !chip_select_out_n && !serial_clock_out))
      else $error("write did not start a transfer");
   // select is low throughout a transfer
   a_cs_busy: assert property (@(posedge clk) disable iff (rst)
      busy |-> !chip_select_out_n)
      else $error("select high during shift");
   // hold bit latched from bit 28
   a_hold_latch: assert property (@(posedge clk) disable iff (rst)
      take |=> (st_reg.hold == $past(rd_s.data[HOLD_BIT])))
      else $error("hold bit not taken from bit 28");

   // pin timing checks: first bit, clock half lengths, data stability and idle clock level
   // first bit is the msb
   a_first_msb: assert property (@(posedge clk) disable iff (rst)
      take |=> (master_serial_out == $past(rd_s.data[DATA_W-1])))
      else $error("first bit was not the msb of the word");
   a_sclk_high: assert property (@(posedge clk) disable iff (rst)
      $rose(serial_clock_out) |-> serial_clock_out[*8] ##1 !serial_clock_out)
      else $error("serial clock high half has the wrong length");
   a_sclk_low: assert property (@(posedge clk) disable iff (rst)
      ($fell(serial_clock_out) && busy) |-> (!serial_clock_out)[*8] ##1 serial_clock_out)
      else $error("serial clock low half has the wrong length");
   // data steady while clock is high
   a_mosi_steady: assert property (@(posedge clk) disable iff (rst)
      serial_clock_out |-> $stable(master_serial_out))
      else $error("serial data moved while the clock was high");
   a_idle_clk_low: assert property (@(posedge clk) disable iff (rst)
      (st_reg.state == SMCH_IDLE) |-> !serial_clock_out)
      else $error("serial clock high while idle");
   // bit counter stays inside one word
   a_bit_range: assert property (@(posedge clk) disable iff (rst)
      busy |-> (st_reg.bitcnt <= BIT_LAST))
      else $error("bit counter ran past the last bit");
   // writer stalled only when a word waits for the engine
   a_ready_stall: assert property (@(posedge clk) disable iff (rst)
      !tx_ready |-> rd_s.valid)
      else $error("writer stalled with no word waiting");
   // no clock while select is held
   a_hold_no_clk: assert property (@(posedge clk) disable iff (rst)
      (st_reg.state == SMCH_HOLD) |-> !serial_clock_out)
      else $error("serial clock moved while select was held");
   // held select survives master mode dropping
   a_hold_mode: assert property (@(posedge clk) disable iff (rst)
      (st_reg.state == SMCH_HOLD && !master_mode) |=> !chip_select_out_n)
      else $error("held select released when master mode dropped");
   a_idle_released: assert property (@(posedge clk) disable iff (rst)
      (st_reg.state == SMCH_IDLE) |-> chip_select_out_n)
      else $error("select low while idle");
   // select rises only with the clock low
   a_rise_clk_low: assert property (@(posedge clk) disable iff (rst)
      $rose(chip_select_out_n) |-> (!serial_clock_out && st_reg.state == SMCH_IDLE))
      else $error("select rose with the clock high or outside idle");
   // select rises only at the end of a shifted word
   a_release_done: assert property (@(posedge clk) disable iff (rst)
      $rose(chip_select_out_n) |-> $past(busy))
      else $error("select rose without a completed word");
   // a waiting engine stays put outside master mode
   a_wait_mode: assert property (@(posedge clk) disable iff (rst)
      (can_take(st_reg.state) && !master_mode) |=> !busy)
      else $error("engine started while master mode was off");
endmodule

// *** hdl/smch_pkg.sv ***
package smch_pkg;
   // combined transmit word layout
   localparam int WORD_W = 32;
   localparam int DATA_W = 16;
   localparam int HOLD_BIT = 28;
   // serial clock timing in core cycles per half period
   localparam int SCLK_HALF_NS = 64;
   localparam int CLK_NS = 8;
   localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [7:0] HALF_RELOAD = 8'(SCLK_HALF_CYC - 1);
   localparam int FIFO_DEPTH = 4;
   localparam logic [4:0] BIT_LAST = 5'h0f;
   typedef enum logic [1:0] {SMCH_IDLE, SMCH_SHIFT, SMCH_HOLD} smch_state_t;
endpackage

// *** hdl/smch_if.sv ***
`timescale 1ns/1ps
interface smch_if #(parameter int W = 32);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// *** hdl/smch_fifo.sv ***
`timescale 1ns/1ps
module smch_fifo #(
   parameter int W = 32,
   parameter int DEPTH = 4
) (
   input wire logic clk,
   input wire logic rst,
   smch_if.snk in_s,
   smch_if.src out_s
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW:0] wr_ptr;
      logic [AW:0] rd_ptr;
      logic [W-1:0] dout;
      logic dvalid;
   } smch_fifo_st_t;
   smch_fifo_st_t st_reg, st_next;
   logic [W-1:0] mem [DEPTH];
   logic full, empty, push, pop, load;
   logic [AW:0] used;
   // storage writes kept outside the state struct to avoid a huge reset
   always_ff @(posedge clk) begin
      if (push) begin
         mem[st_reg.wr_ptr[AW-1:0]] <= in_s.data;
      end
   end
   // the output register is one of the DEPTH slots, so the writer is stalled
   // once storage plus output together hold DEPTH words
   assign used = (st_reg.wr_ptr - st_reg.rd_ptr) + {{AW{1'b0}}, st_reg.dvalid};
   assign full = used >= (AW+1)'(DEPTH);
   assign empty = st_reg.wr_ptr == st_reg.rd_ptr;
   assign in_s.ready = !full;
   assign push = in_s.valid && !full;
   assign pop = out_s.ready && st_reg.dvalid;
   assign load = !empty && (!st_reg.dvalid || pop);
   assign out_s.valid = st_reg.dvalid;
   assign out_s.data = st_reg.dout;
   // output word comes from a register
   always_comb begin
      st_next = st_reg;
      if (push) begin
         st_next.wr_ptr = st_reg.wr_ptr + 1'b1;
      end
      if (load) begin
         st_next.dout = mem[st_reg.rd_ptr[AW-1:0]];
         st_next.rd_ptr = st_reg.rd_ptr + 1'b1;
         st_next.dvalid = 1'b1;
      end else if (pop) begin
         st_next.dvalid = 1'b0;
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
endmodule

// *** tb/smch_slave.sv ***
`timescale 1ns/1ps
// serial slave: samples mode 0 data on the rising clock while selected
module smch_slave (
   input wire logic serial_clock_out,
   input wire logic master_serial_out,
   input wire logic chip_select_out_n,
   output logic [15:0] last_word,
   output int word_count,
   output int select_rises
);
   logic [15:0] sh;
   int n = 0;
   initial begin
      word_count = 0;
      select_rises = 0;
   end
   // msb first, sixteen bits make a word
   always @(posedge serial_clock_out) begin
      if (!chip_select_out_n) begin
         sh = {sh[14:0], master_serial_out};
         n++;
         if (n == 16) begin
            last_word = sh;
            word_count++;
            n = 0;
         end
      end
   end
   // every release is counted so that a short glitch cannot hide
   always @(posedge chip_select_out_n) begin
      select_rises++;
      n = 0;
   end
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
   import smch_pkg::*;
   logic clk = 0, rst = 1, mode = 1, we = 0, sclk, mosi, cs_n, busy, rdy;
   logic [WORD_W-1:0] word = '0;
   logic [15:0] rx;
   int wc, rs, err_count = 0, total_checks = 0, n0, r0;
   smch_master dut (.clk(clk), .rst(rst), .master_mode(mode), .tx_control_data_word(word),
      .tx_write(we), .tx_ready(rdy), .serial_clock_out(sclk), .master_serial_out(mosi),
      .chip_select_out_n(cs_n), .busy(busy));
   smch_slave slv (.serial_clock_out(sclk), .master_serial_out(mosi),
      .chip_select_out_n(cs_n), .last_word(rx), .word_count(wc), .select_rises(rs));
   initial forever #4 clk = ~clk;
   task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // one write pulse per word, changed just after the edge
   task wr(input logic [31:0] w);
      @(posedge clk);
      word <= w;
      we <= 1'b1;
      @(posedge clk);
      we <= 1'b0;
   endtask
   // bounded waits: words seen by the slave, then select released
   task wait_words(input int n);
      for (int i = 0; i < 3000 && wc < n; i++) @(posedge clk);
      if (wc < n) begin
         chk("word timeout", wc, n);
         end_sim();
      end
   endtask
   task wait_rel;
      for (int i = 0; i < 40 && cs_n !== 1'b1; i++) @(posedge clk);
      chk("select released", cs_n, 1'b1);
      if (cs_n !== 1'b1) end_sim();
   endtask
   task t_reset;
      chk("reset select", cs_n, 1'b1);
      chk("reset sclk", sclk, 1'b0);
      chk("reset busy", busy, 1'b0);
      chk("reset ready", rdy, 1'b1);
      $display("test reset done");
   endtask
   // two-word burst: hold on the first, cleared on the last
   task t_burst;
      n0 = wc;
      r0 = rs;
      wr(32'h10001234);
      wr(32'h00005678);
      wait_words(n0 + 1);
      chk("first word", rx, 16'h1234);
      chk("busy mid word", busy, 1'b1);
      repeat (12) @(posedge clk);
      chk("held select", cs_n, 1'b0);
      chk("no early release", rs - r0, 0);
      wait_words(n0 + 2);
      chk("second word", rx, 16'h5678);
      wait_rel();
      chk("one release", rs - r0, 1);
      $display("test burst done");
   endtask
   // held select must survive a long idle gap
   task t_idle;
      n0 = wc;
      r0 = rs;
      wr(32'h1000abcd);
      wait_words(n0 + 1);
      repeat (300) @(posedge clk);
      chk("idle hold", cs_n, 1'b0);
      chk("idle not busy", busy, 1'b0);
      chk("idle clock low", sclk, 1'b0);
      wr(32'h000000ff);
      wait_words(n0 + 2);
      chk("tail word", rx, 16'h00ff);
      wait_rel();
      chk("no glitch", rs - r0, 1);
      $display("test idle done");
   endtask
   // words wait in the fifo until master mode; a fifth write is refused
   task t_mode;
      n0 = wc;
      r0 = rs;
      @(posedge clk);
      mode <= 1'b0;
      for (int i = 1; i <= 4; i++) wr(32'(i));
      @(posedge clk);
      chk("fifo full", rdy, 1'b0);
      wr(32'h0000ffff);
      repeat (50) @(posedge clk);
      chk("no master mode", cs_n, 1'b1);
      mode <= 1'b1;
      wait_words(n0 + 4);
      chk("last queued", rx, 16'h0004);
      repeat (400) @(posedge clk);
      chk("refused dropped", wc - n0, 4);
      chk("four releases", rs - r0, 4);
      $display("test mode done");
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_burst();
      t_idle();
      t_mode();
      end_sim();
   end
endmodule
